/* File: rtl/runt_reference_trigger_detector.sv */
// module: runt reference trigger detector with an AXI4-Lite register file
`timescale 1ns/1ps
module runt_reference_trigger_detector
  import runt_trig_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire compare_type             compareIn [NUM_DETECTORS],
  output logic                         refTrigger,
  output logic                         triggerArmed,
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready
);

  logic [31:0]            ctrl_reg,   ctrl_next;
  logic [31:0]            hiTh_reg,   hiTh_next;
  logic [31:0]            loTh_reg,   loTh_next;
  logic [31:0]            quiet_reg,  quiet_next;
  logic [31:0]            tLow_reg,   tLow_next;
  logic [31:0]            tHigh_reg,  tHigh_next;
  logic [31:0]            pos_reg,    pos_next;
  logic [31:0]            count_reg,  count_next;
  logic [31:0]            trigCnt_reg, trigCnt_next;
  logic                   trig_reg,   trig_next;
  logic                   awHeld_reg, awHeld_next;
  logic                   wHeld_reg,  wHeld_next;
  logic [7:0]             awAddr_reg, awAddr_next;
  logic [31:0]            wData_reg,  wData_next;
  logic [3:0]             wStrb_reg,  wStrb_next;
  logic                   bValid_reg, bValid_next;
  logic [1:0]             bResp_reg,  bResp_next;
  logic                   rValid_reg, rValid_next;
  logic [1:0]             rResp_reg,  rResp_next;
  logic [31:0]            rData_reg,  rData_next;
  logic                   hiS1_reg [NUM_DETECTORS];
  logic                   hiS2_reg [NUM_DETECTORS];
  logic                   loS1_reg [NUM_DETECTORS];
  logic                   loS2_reg [NUM_DETECTORS];
  logic [TDC_WIDTH-1:0]   tdcS1_reg [NUM_DETECTORS];
  logic [TDC_WIDTH-1:0]   tdcS2_reg [NUM_DETECTORS];
  runt_cfg_type           cfg;
  logic                   armed;
  logic                   runtHit;
  logic                   doWrite;
  logic                   selIdx;

  // merge a word under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        res[b*8 +: 8] = nw[b*8 +: 8];
    return res;
  endfunction

  // offset decode shared by read and write paths
  function automatic logic mapped(input logic [7:0] a);
    return (a == CTRL_OFFSET) || (a == HIGH_TH_OFFSET) || (a == LOW_TH_OFFSET)
        || (a == QUIET_OFFSET) || (a == TLOW_OFFSET) || (a == THIGH_OFFSET)
        || (a == STATUS_OFFSET) || (a == POS_OFFSET);
  endfunction

  // comparator pins come from the analog domain: two flip-flops each
  genvar g;
  generate
    for (g = 0; g < NUM_DETECTORS; g++)
    begin : syncGen
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          hiS1_reg[g]  <= 1'b0;
          hiS2_reg[g]  <= 1'b0;
          loS1_reg[g]  <= 1'b0;
          loS2_reg[g]  <= 1'b0;
          tdcS1_reg[g] <= '0;
          tdcS2_reg[g] <= '0;
        end
        else
        begin
          hiS1_reg[g]  <= compareIn[g].aboveHigh;
          hiS2_reg[g]  <= hiS1_reg[g];
          loS1_reg[g]  <= compareIn[g].aboveLow;
          loS2_reg[g]  <= loS1_reg[g];
          tdcS1_reg[g] <= compareIn[g].tdcFraction;
          tdcS2_reg[g] <= tdcS1_reg[g];
        end
      end
    end
  endgenerate

  // configuration view of the registers
  always_comb
  begin
    cfg.enable        = ctrl_reg[CTRL_ENABLE_BIT];
    cfg.detectorSel   = ctrl_reg[CTRL_LOC_BIT];
    cfg.tdcEnable     = ctrl_reg[CTRL_TDC_BIT];
    cfg.timeCond      = time_cond_type'(ctrl_reg[CTRL_TCOND_LSB +: 2]);
    cfg.polarity      = polarity_type'(ctrl_reg[CTRL_POL_LSB +: 2]);
    cfg.highThreshold = hiTh_reg[SAMPLE_WIDTH-1:0];
    cfg.lowThreshold  = loTh_reg[SAMPLE_WIDTH-1:0];
    cfg.quietCycles   = quiet_reg;
    cfg.timeLow       = tLow_reg;
    cfg.timeHigh      = tHigh_reg;
  end

  assign selIdx = cfg.detectorSel;

  runt_pulse_classifier classifier (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .cfg       (cfg),
    .aboveHigh (hiS2_reg[selIdx]),
    .aboveLow  (loS2_reg[selIdx]),
    .armed     (armed),
    .runtHit   (runtHit)
  );

  assign refTrigger    = trig_reg;
  assign triggerArmed  = armed;
  assign doWrite       = awHeld_reg && wHeld_reg && !bValid_reg;
  assign s_axi_awready = !awHeld_reg && !bValid_reg;
  assign s_axi_wready  = !wHeld_reg && !bValid_reg;
  assign s_axi_arready = !rValid_reg;
  assign s_axi_bvalid  = bValid_reg;
  assign s_axi_bresp   = bResp_reg;
  assign s_axi_rvalid  = rValid_reg;
  assign s_axi_rresp   = rResp_reg;
  assign s_axi_rdata   = rData_reg;

  // next values: bus slave, registers, trigger position
  always_comb
  begin
    ctrl_next    = ctrl_reg;
    hiTh_next    = hiTh_reg;
    loTh_next    = loTh_reg;
    quiet_next   = quiet_reg;
    tLow_next    = tLow_reg;
    tHigh_next   = tHigh_reg;
    awHeld_next  = awHeld_reg;
    wHeld_next   = wHeld_reg;
    awAddr_next  = awAddr_reg;
    wData_next   = wData_reg;
    wStrb_next   = wStrb_reg;
    bValid_next  = bValid_reg && !s_axi_bready;
    bResp_next   = bResp_reg;
    rValid_next  = rValid_reg && !s_axi_rready;
    rResp_next   = rResp_reg;
    rData_next   = rData_reg;
    count_next   = count_reg + 1'b1;
    trig_next    = runtHit;
    pos_next     = pos_reg;
    trigCnt_next = trigCnt_reg;
    if (runtHit)
    begin
      trigCnt_next = trigCnt_reg + 1'b1;
      if (cfg.tdcEnable)
        pos_next = {count_reg[31-TDC_WIDTH:0], tdcS2_reg[selIdx]};
      else
        pos_next = {count_reg[31-TDC_WIDTH:0], {TDC_WIDTH{1'b0}}};
    end
    if (s_axi_awvalid && s_axi_awready)
    begin
      awHeld_next = 1'b1;
      awAddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      wHeld_next = 1'b1;
      wData_next = s_axi_wdata;
      wStrb_next = s_axi_wstrb;
    end
    if (doWrite)
    begin
      awHeld_next = 1'b0;
      wHeld_next  = 1'b0;
      bValid_next = 1'b1;
      bResp_next  = mapped(awAddr_reg) ? RESP_OKAY : RESP_DECERR;
      if (awAddr_reg == CTRL_OFFSET)
        ctrl_next = merge(ctrl_reg, wData_reg, wStrb_reg);
      else if (awAddr_reg == HIGH_TH_OFFSET)
        hiTh_next = merge(hiTh_reg, wData_reg, wStrb_reg);
      else if (awAddr_reg == LOW_TH_OFFSET)
        loTh_next = merge(loTh_reg, wData_reg, wStrb_reg);
      else if (awAddr_reg == QUIET_OFFSET)
        quiet_next = merge(quiet_reg, wData_reg, wStrb_reg);
      else if (awAddr_reg == TLOW_OFFSET)
        tLow_next = merge(tLow_reg, wData_reg, wStrb_reg);
      else if (awAddr_reg == THIGH_OFFSET)
        tHigh_next = merge(tHigh_reg, wData_reg, wStrb_reg);
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      rValid_next = 1'b1;
      rResp_next  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
      if (s_axi_araddr == CTRL_OFFSET)
        rData_next = ctrl_reg;
      else if (s_axi_araddr == HIGH_TH_OFFSET)
        rData_next = hiTh_reg;
      else if (s_axi_araddr == LOW_TH_OFFSET)
        rData_next = loTh_reg;
      else if (s_axi_araddr == QUIET_OFFSET)
        rData_next = quiet_reg;
      else if (s_axi_araddr == TLOW_OFFSET)
        rData_next = tLow_reg;
      else if (s_axi_araddr == THIGH_OFFSET)
        rData_next = tHigh_reg;
      else if (s_axi_araddr == STATUS_OFFSET)
        rData_next = {trigCnt_reg[30:0], armed};
      else if (s_axi_araddr == POS_OFFSET)
        rData_next = pos_reg;
      else
        rData_next = '0;
    end
  end

  // registers of the bus slave and trigger outputs
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg    <= CTRL_RESET;
      hiTh_reg    <= '0;
      loTh_reg    <= '0;
      quiet_reg   <= QUIET_RESET;
      tLow_reg    <= '0;
      tHigh_reg   <= '0;
      pos_reg     <= '0;
      count_reg   <= '0;
      trigCnt_reg <= '0;
      trig_reg    <= 1'b0;
      awHeld_reg  <= 1'b0;
      wHeld_reg   <= 1'b0;
      awAddr_reg  <= '0;
      wData_reg   <= '0;
      wStrb_reg   <= '0;
      bValid_reg  <= 1'b0;
      bResp_reg   <= RESP_OKAY;
      rValid_reg  <= 1'b0;
      rResp_reg   <= RESP_OKAY;
      rData_reg   <= '0;
    end
    else
    begin
      ctrl_reg    <= ctrl_next;
      hiTh_reg    <= hiTh_next;
      loTh_reg    <= loTh_next;
      quiet_reg   <= quiet_next;
      tLow_reg    <= tLow_next;
      tHigh_reg   <= tHigh_next;
      pos_reg     <= pos_next;
      count_reg   <= count_next;
      trigCnt_reg <= trigCnt_next;
      trig_reg    <= trig_next;
      awHeld_reg  <= awHeld_next;
      wHeld_reg   <= wHeld_next;
      awAddr_reg  <= awAddr_next;
      wData_reg   <= wData_next;
      wStrb_reg   <= wStrb_next;
      bValid_reg  <= bValid_next;
      bResp_reg   <= bResp_next;
      rValid_reg  <= rValid_next;
      rResp_reg   <= rResp_next;
      rData_reg   <= rData_next;
    end
  end

endmodule

/* File: rtl/runt_trig_pkg.sv */
// package: register map, field codes and carrier types of the runt trigger detector
package runt_trig_pkg;

  localparam int          SAMPLE_WIDTH   = 16;
  localparam int          COUNT_WIDTH    = 32;
  localparam int          TDC_WIDTH      = 8;
  localparam int          NUM_DETECTORS  = 2;

  // register byte offsets
  localparam logic [7:0]  CTRL_OFFSET     = 8'h00;
  localparam logic [7:0]  HIGH_TH_OFFSET  = 8'h04;
  localparam logic [7:0]  LOW_TH_OFFSET   = 8'h08;
  localparam logic [7:0]  QUIET_OFFSET    = 8'h0c;
  localparam logic [7:0]  TLOW_OFFSET     = 8'h10;
  localparam logic [7:0]  THIGH_OFFSET    = 8'h14;
  localparam logic [7:0]  STATUS_OFFSET   = 8'h18;
  localparam logic [7:0]  POS_OFFSET      = 8'h1c;

  // control field positions
  localparam int          CTRL_POL_LSB    = 0;
  localparam int          CTRL_TCOND_LSB  = 2;
  localparam int          CTRL_TDC_BIT    = 4;
  localparam int          CTRL_LOC_BIT    = 5;
  localparam int          CTRL_ENABLE_BIT = 6;

  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam logic [31:0] QUIET_RESET     = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_DECERR     = 2'b11;

  typedef enum logic [1:0] {
    POL_POSITIVE = 2'h0,
    POL_NEGATIVE = 2'h1,
    POL_EITHER   = 2'h2
  } polarity_type;

  typedef enum logic [1:0] {
    TCOND_NONE    = 2'h0,
    TCOND_INSIDE  = 2'h1,
    TCOND_OUTSIDE = 2'h2
  } time_cond_type;

  // configuration carried from register file to detector
  typedef struct packed {
    logic                            enable;
    logic                            detectorSel;
    logic                            tdcEnable;
    time_cond_type                   timeCond;
    polarity_type                    polarity;
    logic signed [SAMPLE_WIDTH-1:0]  highThreshold;
    logic signed [SAMPLE_WIDTH-1:0]  lowThreshold;
    logic [COUNT_WIDTH-1:0]          quietCycles;
    logic [COUNT_WIDTH-1:0]          timeLow;
    logic [COUNT_WIDTH-1:0]          timeHigh;
  } runt_cfg_type;

  // comparator outputs of one analog compare circuit
  typedef struct packed {
    logic                  aboveHigh;
    logic                  aboveLow;
    logic [TDC_WIDTH-1:0]  tdcFraction;
  } compare_type;

endpackage

/* File: rtl/runt_pulse_classifier.sv */
// module: runt pulse classifier with quiet-time arming and duration qualification
`timescale 1ns/1ps
module runt_pulse_classifier
  import runt_trig_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire runt_cfg_type cfg,
  input  wire logic         aboveHigh,
  input  wire logic         aboveLow,
  output logic              armed,
  output logic              runtHit
);

  typedef enum logic [3:0] {
    ST_DISARMED = 4'b0001,
    ST_IDLE     = 4'b0010,
    ST_POS      = 4'b0100,
    ST_NEG      = 4'b1000
  } state_type;

  state_type              state_reg,  state_next;
  logic [COUNT_WIDTH-1:0] quiet_reg,  quiet_next;
  logic [COUNT_WIDTH-1:0] width_reg,  width_next;
  logic                   hit_reg,    hit_next;
  logic                   aboveLow_reg;
  logic                   aboveHigh_reg;
  logic                   widthOk;
  logic                   posOk;
  logic                   negOk;

  // duration check against the programmed limits
  always_comb
  begin
    case (cfg.timeCond)
      TCOND_INSIDE:  widthOk = (width_reg >= cfg.timeLow) && (width_reg <= cfg.timeHigh);
      TCOND_OUTSIDE: widthOk = (width_reg < cfg.timeLow) || (width_reg > cfg.timeHigh);
      default:       widthOk = 1'b1;
    endcase
  end

  assign posOk = (cfg.polarity == POL_POSITIVE) || (cfg.polarity == POL_EITHER);
  assign negOk = (cfg.polarity == POL_NEGATIVE) || (cfg.polarity == POL_EITHER);
  assign armed   = (state_reg != ST_DISARMED);
  assign runtHit = hit_reg;

  // next state of the pulse tracker
  always_comb
  begin
    state_next = state_reg;
    quiet_next = quiet_reg;
    width_next = width_reg + 1'b1;
    hit_next   = 1'b0;
    case (state_reg)
      ST_DISARMED:
      begin
        // stay quiet at or below trigger level for the full interval
        if (!cfg.enable || aboveLow || aboveHigh)
          quiet_next = '0;
        else if (quiet_reg >= cfg.quietCycles)
          state_next = ST_IDLE;
        else
          quiet_next = quiet_reg + 1'b1;
      end
      ST_IDLE:
      begin
        width_next = '0;
        if (!cfg.enable)
          state_next = ST_DISARMED;
        else if (aboveLow && !aboveLow_reg && !aboveHigh && posOk)
          state_next = ST_POS;
        else if (!aboveHigh && aboveHigh_reg && aboveLow && negOk)
          state_next = ST_NEG;
      end
      ST_POS:
      begin
        if (aboveHigh)
          state_next = ST_IDLE;
        else if (!aboveLow)
        begin
          hit_next   = widthOk;
          state_next = ST_DISARMED;
          quiet_next = '0;
        end
      end
      ST_NEG:
      begin
        if (!aboveLow)
          state_next = ST_IDLE;
        else if (aboveHigh)
        begin
          hit_next   = widthOk;
          state_next = ST_DISARMED;
          quiet_next = '0;
        end
      end
      default: state_next = ST_DISARMED;
    endcase
  end

  // state registers, sampled every clock
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg     <= ST_DISARMED;
      quiet_reg     <= '0;
      width_reg     <= '0;
      hit_reg       <= 1'b0;
      aboveLow_reg  <= 1'b0;
      aboveHigh_reg <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      quiet_reg     <= quiet_next;
      width_reg     <= width_next;
      hit_reg       <= hit_next;
      aboveLow_reg  <= aboveLow;
      aboveHigh_reg <= aboveHigh;
    end
  end

endmodule

/* File: sim/runt_front_end_model.sv */
// model: analog compare front end feeding both compare circuits
`timescale 1ns/1ps
module runt_front_end_model
  import runt_trig_pkg::*;
(
  input  wire logic [1:0]  lvl [NUM_DETECTORS],
  input  wire logic [7:0]  tdcCode,
  output compare_type      compareIn [NUM_DETECTORS]
);
  // level 0 below low, 1 inside window, 2 above high
  always_comb
  begin
    for (int i = 0; i < NUM_DETECTORS; i++)
    begin
      compareIn[i].aboveLow    = lvl[i] != 2'd0;
      compareIn[i].aboveHigh   = lvl[i] == 2'd2;
      compareIn[i].tdcFraction = tdcCode;
    end
  end
endmodule

/* File: sim/runt_reference_trigger_detector_checker.sv */
// checker: port assertions of the runt reference trigger detector
`timescale 1ns/1ps
module runt_trig_checker
  import runt_trig_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire compare_type compareIn [NUM_DETECTORS],
  input wire logic        refTrigger,
  input wire logic        triggerArmed,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready
);
  logic [3:0] bits;
  logic [3:0] bitsReg;
  logic       changed;
  logic       quietAll;
  // comparator bits of both circuits and their change
  assign bits = {compareIn[1].aboveHigh, compareIn[1].aboveLow,
                 compareIn[0].aboveHigh, compareIn[0].aboveLow};
  assign changed  = bits != bitsReg;
  assign quietAll = bits == 4'h0;
  // previous comparator bits
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      bitsReg <= 4'h0;
    else
      bitsReg <= bits;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_pulse_ends;
    refTrigger ##1 !refTrigger;
  endsequence
  sequence s_recent_cross;
    $past(changed, 2) || $past(changed, 3) || $past(changed, 4) || $past(changed, 5);
  endsequence

  a_trig_one_cycle: assert property (refTrigger |-> s_pulse_ends)
    else $error("trigger pulse longer than one cycle");
  a_trig_from_armed: assert property ($rose(refTrigger) |-> $past(triggerArmed, 2))
    else $error("trigger while disarmed");
  a_disarm_on_trig: assert property (refTrigger |-> !triggerArmed)
    else $error("still armed after trigger");
  a_arm_after_quiet: assert property ($rose(triggerArmed) |-> $past(quietAll, 3))
    else $error("armed without quiet input");
  a_reset_idle: assert property ($rose(rst_n) |-> !triggerArmed && !refTrigger)
    else $error("not idle after reset");
  a_trig_after_cross: assert property ($rose(refTrigger) |-> s_recent_cross)
    else $error("trigger without a recent crossing");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule

bind runt_reference_trigger_detector runt_trig_checker i_chk (
  .mclk(mclk), .rst_n(rst_n), .compareIn(compareIn), .refTrigger(refTrigger),
  .triggerArmed(triggerArmed), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));

/* File: sim/tb_runt_reference_trigger_detector.sv */
// testbench: runt reference trigger detector with register bus and front end model
`timescale 1ns/1ps
module tb_runt_reference_trigger_detector;
  import runt_trig_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [1:0]  lvl [NUM_DETECTORS] = '{2'd0, 2'd0};
  logic [7:0]  tdcCode = 8'h5a;
  compare_type compareIn [NUM_DETECTORS];
  logic        refTrigger, triggerArmed;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] d, c0;
  logic [1:0]  r;
  int          n_mismatch = 0;
  int          check_count = 0;

  // clock
  always #4 mclk = ~mclk;

  runt_front_end_model i_fe (.lvl(lvl), .tdcCode(tdcCode), .compareIn(compareIn));
  runt_reference_trigger_detector i_dut (
    .mclk(mclk), .rst_n(rst_n), .compareIn(compareIn), .refTrigger(refTrigger),
    .triggerArmed(triggerArmed), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // write one word, ready sampled mid-cycle, released after the taking edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic awT, wT, done;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done)
    begin
      @(negedge mclk);
      awT = s_axi_awvalid && s_axi_awready;
      wT = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge mclk);
      if (awT) s_axi_awvalid <= 1'b0;
      if (wT) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    // let an edge pass so a following call does not reassign bready in this step
    @(posedge mclk);
    check({30'h0, r}, {30'h0, er});
  endtask

  // read one word and its response
  task automatic axi_read(input logic [7:0] a);
    logic arT, done;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done)
    begin
      @(negedge mclk);
      arT = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      if (arT) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    // let an edge pass so a following call does not reassign rready in this step
    @(posedge mclk);
  endtask

  // enable with polarity, time condition, refinement and location
  task automatic cfg(input logic [1:0] p, input logic [1:0] t, input logic tdc, input logic loc);
    axi_write(CTRL_OFFSET, {25'h0, 1'b1, loc, tdc, t, p}, RESP_OKAY);
  endtask

  // drive both inputs quiet and wait for arming
  task automatic arm();
    lvl[0] <= 2'd0;
    lvl[1] <= 2'd0;
    // look at the armed flag mid-cycle, where it is settled
    @(negedge mclk);
    for (int i = 0; i < 60 && triggerArmed !== 1'b1; i++) @(negedge mclk);
    check({31'h0, triggerArmed}, 32'h1);
    @(posedge mclk);
  endtask

  // leave base through the window to peak, back to base, watch for a trigger
  task automatic pulse(input int k, input logic [1:0] base, peak, input int w, input logic exp);
    logic seen;
    seen = 1'b0;
    lvl[k] <= 2'd1;
    step(2);
    lvl[k] <= peak;
    step(w);
    lvl[k] <= 2'd1;
    step(2);
    lvl[k] <= base;
    repeat (12)
    begin
      @(negedge mclk);
      seen = seen | refTrigger;
    end
    @(posedge mclk);
    check({31'h0, seen}, {31'h0, exp});
  endtask

  task automatic go_high();
    lvl[0] <= 2'd1;
    step(2);
    lvl[0] <= 2'd2;
    step(4);
  endtask

  task automatic test_regs();
    check({30'h0, triggerArmed, refTrigger}, 32'h0);
    axi_read(CTRL_OFFSET);
    check(d, CTRL_RESET);
    axi_read(QUIET_OFFSET);
    check(d, QUIET_RESET);
    axi_write(HIGH_TH_OFFSET, 32'h0000_1234, RESP_OKAY);
    axi_write(LOW_TH_OFFSET, 32'h0000_00f0, RESP_OKAY);
    axi_read(HIGH_TH_OFFSET);
    check({16'h0, d[15:0]}, 32'h0000_1234);
    axi_read(LOW_TH_OFFSET);
    check({16'h0, d[15:0]}, 32'h0000_00f0);
    axi_write(CTRL_OFFSET, 32'h0000_0020, RESP_OKAY);
    axi_read(CTRL_OFFSET);
    check(d, 32'h0000_0020);
    axi_write(8'h40, 32'hffff_ffff, RESP_DECERR);
    axi_read(8'h40);
    check({r, d[29:0]}, {RESP_DECERR, 30'h0});
    $display("test_regs done");
  endtask

  task automatic test_quiet();
    lvl[0] <= 2'd1;
    axi_write(QUIET_OFFSET, 32'd30, RESP_OKAY);
    cfg(POL_POSITIVE, TCOND_NONE, 1'b0, 1'b0);
    step(10);
    lvl[0] <= 2'd0;
    step(20);
    lvl[0] <= 2'd1;
    step(1);
    lvl[0] <= 2'd0;
    step(25);
    check({31'h0, triggerArmed}, 32'h0);
    arm();
    $display("test_quiet done");
  endtask

  task automatic test_polarity();
    axi_write(QUIET_OFFSET, 32'd4, RESP_OKAY);
    axi_read(STATUS_OFFSET);
    c0 = d;
    arm();
    pulse(0, 2'd0, 2'd1, 6, 1'b1);
    arm();
    pulse(0, 2'd0, 2'd2, 6, 1'b0);
    cfg(POL_NEGATIVE, TCOND_NONE, 1'b0, 1'b0);
    arm();
    go_high();
    pulse(0, 2'd2, 2'd0, 6, 1'b0);
    pulse(0, 2'd2, 2'd1, 6, 1'b1);
    cfg(POL_EITHER, TCOND_NONE, 1'b0, 1'b0);
    arm();
    pulse(0, 2'd0, 2'd1, 6, 1'b1);
    arm();
    go_high();
    pulse(0, 2'd2, 2'd1, 6, 1'b1);
    axi_read(STATUS_OFFSET);
    check({1'b0, d[31:1] - c0[31:1]}, 32'd4);
    $display("test_polarity done");
  endtask

  task automatic test_location();
    cfg(POL_POSITIVE, TCOND_NONE, 1'b0, 1'b1);
    arm();
    pulse(0, 2'd0, 2'd1, 6, 1'b0);
    pulse(1, 2'd0, 2'd1, 6, 1'b1);
    $display("test_location done");
  endtask

  task automatic test_tdc();
    cfg(POL_POSITIVE, TCOND_NONE, 1'b1, 1'b0);
    arm();
    pulse(0, 2'd0, 2'd1, 6, 1'b1);
    axi_read(POS_OFFSET);
    check({24'h0, d[7:0]}, {24'h0, tdcCode});
    cfg(POL_POSITIVE, TCOND_NONE, 1'b0, 1'b0);
    arm();
    pulse(0, 2'd0, 2'd1, 6, 1'b1);
    axi_read(POS_OFFSET);
    check({24'h0, d[7:0]}, 32'h0);
    $display("test_tdc done");
  endtask

  task automatic test_time();
    axi_write(TLOW_OFFSET, 32'd8, RESP_OKAY);
    axi_write(THIGH_OFFSET, 32'd20, RESP_OKAY);
    cfg(POL_POSITIVE, TCOND_INSIDE, 1'b0, 1'b0);
    arm();
    pulse(0, 2'd0, 2'd1, 8, 1'b1);
    arm();
    pulse(0, 2'd0, 2'd1, 40, 1'b0);
    cfg(POL_POSITIVE, TCOND_OUTSIDE, 1'b0, 1'b0);
    arm();
    pulse(0, 2'd0, 2'd1, 40, 1'b1);
    $display("test_time done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // watchdog
  initial
  begin
    #200000;
    n_mismatch++;
    end_of_test();
  end

  // main sequence
  initial
  begin
    step(16);
    rst_n <= 1'b1;
    step(1);
    test_regs();
    test_quiet();
    test_polarity();
    test_location();
    test_tdc();
    test_time();
    end_of_test();
  end
endmodule
